// File: shared/cache_line_access_control_defines.svh
// Summary of operation
// - Low four bits pick the target line
// - Enable bit one lets line writes land
// - Enable bit zero leaves target line unchanged
// - Gate covers tag, mask, four words only
`ifndef CACHE_LINE_ACCESS_CONTROL_DEFINES_SVH
`define CACHE_LINE_ACCESS_CONTROL_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_ACCESS_CTRL  5'h00
`define OFS_LINE_TAG     5'h04
`define OFS_LINE_MASK    5'h08
`define OFS_LINE_WORD0   5'h0C
`define OFS_LINE_WORD1   5'h10
`define OFS_LINE_WORD2   5'h14
`define OFS_LINE_WORD3   5'h18

// Field layout of the access control register
`define WEN_BIT          31
`define IDX_MSB          3
`define IDX_LSB          0
`define IDX_WIDTH        4

// Line storage geometry
`define NUM_LINES        16
`define WORDS_PER_LINE   4

// Reset and fill values
`define RESET_WORD       32'h0000_0000
`define RESET_IDX        4'h0
`define BE_ALL           4'hF

`endif

// File: shared/cache_line_access_control_pkg.sv
package cache_line_access_control_pkg;

  // Bus handshake phases: wait one cycle, then answer
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

  typedef logic [31:0] word_t;

endpackage : cache_line_access_control_pkg

// File: src/cache_line_access_control.sv
`timescale 1ns/10ps
`include "cache_line_access_control_defines.svh"

module cache_line_access_control (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             line_write_enable,
  output logic      [3:0]  line_index
);

  ////////////////////////////////////////////////////////////////////////////
  // State declarations

  cache_line_access_control_pkg::bus_state_t state_reg;
  cache_line_access_control_pkg::word_t      readdata_reg;
  cache_line_access_control_pkg::word_t      read_mux;
  logic                                      waitrequest_reg;
  logic                                      wen_reg;
  logic [`IDX_WIDTH-1:0]                     idx_reg;
  logic                                      commit;
  logic                                      line_target;

  cache_line_access_control_pkg::word_t tag_mem  [`NUM_LINES];
  cache_line_access_control_pkg::word_t mask_mem [`NUM_LINES];
  cache_line_access_control_pkg::word_t word_mem [`NUM_LINES][`WORDS_PER_LINE];

  // Byte-lane merge so partial writes keep untouched lanes
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: waitrequest drops for exactly one cycle per request

  // A write lands only at the edge where the master sees waitrequest low
  assign commit = ce && (state_reg == cache_line_access_control_pkg::BUS_ACK)
                  && write;

  // Any line-storage offset, control register excluded
  assign line_target = (address == `OFS_LINE_TAG)   ||
                       (address == `OFS_LINE_MASK)  ||
                       (address == `OFS_LINE_WORD0) ||
                       (address == `OFS_LINE_WORD1) ||
                       (address == `OFS_LINE_WORD2) ||
                       (address == `OFS_LINE_WORD3);

  // Handshake sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg       <= cache_line_access_control_pkg::BUS_IDLE;
      waitrequest_reg <= 1'b1;
    end else if (ce) begin
      case (state_reg)
        cache_line_access_control_pkg::BUS_IDLE: begin
          if (read || write) begin
            state_reg       <= cache_line_access_control_pkg::BUS_ACK;
            waitrequest_reg <= 1'b0;
          end
        end
        cache_line_access_control_pkg::BUS_ACK: begin
          state_reg       <= cache_line_access_control_pkg::BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
        default: begin
          state_reg       <= cache_line_access_control_pkg::BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Unmapped offsets and reserved bits read as zero
  always_comb begin
    read_mux = `RESET_WORD;
    case (address)
      `OFS_ACCESS_CTRL: begin
        read_mux[`WEN_BIT]         = wen_reg;
        read_mux[`IDX_MSB:`IDX_LSB] = idx_reg;
      end
      `OFS_LINE_TAG:   read_mux = tag_mem[idx_reg];
      `OFS_LINE_MASK:  read_mux = mask_mem[idx_reg];
      `OFS_LINE_WORD0: read_mux = word_mem[idx_reg][0];
      `OFS_LINE_WORD1: read_mux = word_mem[idx_reg][1];
      `OFS_LINE_WORD2: read_mux = word_mem[idx_reg][2];
      `OFS_LINE_WORD3: read_mux = word_mem[idx_reg][3];
      default:         read_mux = `RESET_WORD;
    endcase
  end

  // Read data captured as waitrequest drops, stands through the answer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      readdata_reg <= `RESET_WORD;
    end else if (ce && read &&
                 state_reg == cache_line_access_control_pkg::BUS_IDLE) begin
      readdata_reg <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access control register

  // Reserved bits 30-4 are dropped, so stray ones never stick
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wen_reg <= 1'b0;
      idx_reg <= `RESET_IDX;
    end else if (commit && address == `OFS_ACCESS_CTRL) begin
      if (byteenable[3]) begin
        wen_reg <= writedata[`WEN_BIT];
      end
      if (byteenable[0]) begin
        idx_reg <= writedata[`IDX_MSB:`IDX_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line storage, one slice per cache line

  generate
    for (genvar ln = 0; ln < `NUM_LINES; ln++) begin : g_line
      // Only the indexed line, and only while enabled, takes a write
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          tag_mem[ln]  <= `RESET_WORD;
          mask_mem[ln] <= `RESET_WORD;
          for (int w = 0; w < `WORDS_PER_LINE; w++) begin
            word_mem[ln][w] <= `RESET_WORD;
          end
        end else if (commit && wen_reg && line_target &&
                     idx_reg == ln) begin
          case (address)
            `OFS_LINE_TAG:
              tag_mem[ln] <= merge_bytes(tag_mem[ln], writedata, byteenable);
            `OFS_LINE_MASK:
              mask_mem[ln] <= merge_bytes(mask_mem[ln], writedata,
                                          byteenable);
            `OFS_LINE_WORD0:
              word_mem[ln][0] <= merge_bytes(word_mem[ln][0], writedata,
                                             byteenable);
            `OFS_LINE_WORD1:
              word_mem[ln][1] <= merge_bytes(word_mem[ln][1], writedata,
                                             byteenable);
            `OFS_LINE_WORD2:
              word_mem[ln][2] <= merge_bytes(word_mem[ln][2], writedata,
                                             byteenable);
            `OFS_LINE_WORD3:
              word_mem[ln][3] <= merge_bytes(word_mem[ln][3], writedata,
                                             byteenable);
            default: ;
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign readdata          = readdata_reg;
  assign waitrequest       = waitrequest_reg;
  assign line_write_enable = wen_reg;
  assign line_index        = idx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Helper view of the selected line
  cache_line_access_control_pkg::word_t sel_tag;
  cache_line_access_control_pkg::word_t sel_mask;
  cache_line_access_control_pkg::word_t sel_word0;
  assign sel_tag   = tag_mem[idx_reg];
  assign sel_mask  = mask_mem[idx_reg];
  assign sel_word0 = word_mem[idx_reg][0];

  sequence s_idle_req;
    ce && (read || write) &&
      state_reg == cache_line_access_control_pkg::BUS_IDLE;
  endsequence

  sequence s_one_cycle_ack;
    !waitrequest ##1 waitrequest;
  endsequence

  AST_WAIT_ONE_CYCLE: assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_idle_req ##1 ce |-> s_one_cycle_ack)
    else $error("waitrequest not low for exactly one cycle");

  AST_INDEX_WRITE: assert property (
    @(posedge core_clk) disable iff (!resetn)
    commit && address == `OFS_ACCESS_CTRL && byteenable[0]
    |=> idx_reg == $past(writedata[`IDX_MSB:`IDX_LSB]))
    else $error("line index did not take written value");

  AST_READ_SELECTED: assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_idle_req and (read && address == `OFS_LINE_TAG)
    |=> readdata == $past(sel_tag))
    else $error("tag read did not return the selected line");

  AST_WRITE_ALLOWED: assert property (
    @(posedge core_clk) disable iff (!resetn)
    commit && wen_reg && address == `OFS_LINE_WORD0 &&
      byteenable == `BE_ALL
    |=> sel_word0 == $past(writedata))
    else $error("enabled line write did not land");

  AST_WRITE_BLOCKED: assert property (
    @(posedge core_clk) disable iff (!resetn)
    commit && !wen_reg && line_target
    |=> $stable(sel_tag) && $stable(sel_mask) && $stable(sel_word0))
    else $error("disabled line was modified");

  AST_CTRL_UNGATED: assert property (
    @(posedge core_clk) disable iff (!resetn)
    commit && !wen_reg && address == `OFS_ACCESS_CTRL && byteenable[3]
    |=> wen_reg == $past(writedata[`WEN_BIT]))
    else $error("control register write was gated");

  AST_RESERVED_ZERO: assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_idle_req and (read && address == `OFS_ACCESS_CTRL)
    |=> readdata[`WEN_BIT-1:`IDX_MSB+1] == '0)
    else $error("reserved control bits read nonzero");

  AST_RESET_VALUES: assert property (
    @(posedge core_clk)
    resetn && !$past(resetn) |-> !wen_reg && idx_reg == `RESET_IDX
      && waitrequest)
    else $error("control not cleared by reset");

endmodule : cache_line_access_control

// File: tb/cache_line_access_control_bench.sv
`timescale 1ns/10ps
`include "cache_line_access_control_defines.svh"

module cache_line_access_control_bench;
  logic        core_clk;
  logic        resetn;
  logic        ce;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        line_write_enable;
  logic [3:0]  line_index;
  int          bad_count;
  int          check_count;
  logic [4:0]  offs [6];
  logic [31:0] rd;

  cache_line_access_control DUT (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .ce                (ce),
    .address           (address),
    .read              (read),
    .write             (write),
    .writedata         (writedata),
    .byteenable        (byteenable),
    .readdata          (readdata),
    .waitrequest       (waitrequest),
    .line_write_enable (line_write_enable),
    .line_index        (line_index)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(logic is_wr, logic [4:0] addr, logic [31:0] data,
                     logic [3:0] be);
    int n;
    @(posedge core_clk);
    address    <= addr;
    writedata  <= data;
    byteenable <= be;
    read       <= ~is_wr;
    write      <= is_wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      $display("Error waitrequest expected 0 seen %b", waitrequest);
      bad_count++;
      wrap_up();
    end else begin
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
    end
  endtask : bus

  // Register i of a line (tag, mask, then words 0-3) gets base plus i, so swapped lanes show up
  task automatic write_line(logic [31:0] base);
    for (int i = 0; i < 6; i++) bus(1'b1, offs[i], base + i, 4'hF);
  endtask : write_line

  task automatic check_line(logic [31:0] base, bit zero);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, offs[i], 32'h0000_0000, 4'hF);
      check("line_reg", zero ? 32'h0000_0000 : base + i, rd);
    end
  endtask : check_line

  task automatic ctrl_is(logic [31:0] exp);
    bus(1'b0, `OFS_ACCESS_CTRL, 32'h0000_0000, 4'hF);
    check("access_ctrl", exp, rd);
    @(negedge core_clk);
    check("line_write_enable", {31'h0, exp[31]}, {31'h0, line_write_enable});
    check("line_index", {28'h0, exp[3:0]}, {28'h0, line_index});
  endtask : ctrl_is

  task automatic do_reset();
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    offs = '{`OFS_LINE_TAG, `OFS_LINE_MASK, `OFS_LINE_WORD0,
             `OFS_LINE_WORD1, `OFS_LINE_WORD2, `OFS_LINE_WORD3};
    resetn = 1'b0;
    ce = 1'b1;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    ctrl_is(32'h0000_0000);
    check_line(32'h0000_0000, 1'b1);
    // Locked line: all six registers must ignore writes
    bus(1'b1, `OFS_ACCESS_CTRL, 32'h0000_0005, 4'hF);
    ctrl_is(32'h0000_0005);
    write_line(32'hDEAD_0000);
    check_line(32'h0000_0000, 1'b1);
    // Software keeps reserved bits 30-4 at zero on every write
    bus(1'b1, `OFS_ACCESS_CTRL, 32'h8000_0005, 4'hF);
    ctrl_is(32'h8000_0005);
    write_line(32'h1234_0000);
    check_line(32'h1234_0000, 1'b0);
    // Another line must not disturb line 5
    bus(1'b1, `OFS_ACCESS_CTRL, 32'h8000_0006, 4'hF);
    write_line(32'h5678_0000);
    check_line(32'h5678_0000, 1'b0);
    bus(1'b1, `OFS_ACCESS_CTRL, 32'h8000_0005, 4'hF);
    check_line(32'h1234_0000, 1'b0);
    // Lock again; control register itself stays writable
    bus(1'b1, `OFS_ACCESS_CTRL, 32'h0000_0005, 4'hF);
    write_line(32'hBEEF_0000);
    check_line(32'h1234_0000, 1'b0);
    ctrl_is(32'h0000_0005);
    // Unmapped place reads zero and swallows writes
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 5'h1C, 32'h0000_0000, 4'hF);
    check("unmapped", 32'h0000_0000, rd);
    ctrl_is(32'h0000_0005);
    // Low lane only: index moves to the top line, enable untouched
    bus(1'b1, `OFS_ACCESS_CTRL, 32'h8000_000F, 4'h1);
    ctrl_is(32'h0000_000F);
    // Clock enable low: a pending write gets no answer and does not land until ce returns high
    @(posedge core_clk);
    ce <= 1'b0;
    fork
      bus(1'b1, `OFS_ACCESS_CTRL, 32'h8000_0003, 4'hF);
      begin
        repeat (4) @(posedge core_clk);
        check("frozen_wait", 32'h0000_0001, {31'h0, waitrequest});
        check("frozen_index", 32'h0000_000F, {28'h0, line_index});
        ce <= 1'b1;
      end
    join
    ctrl_is(32'h8000_0003);
    // Second reset in mid-run clears control and storage
    do_reset();
    ctrl_is(32'h0000_0000);
    bus(1'b1, `OFS_ACCESS_CTRL, 32'h0000_0005, 4'hF);
    check_line(32'h0000_0000, 1'b1);
    wrap_up();
  end

endmodule : cache_line_access_control_bench
